//--- verilog/tisc_pkg.sv
// Shared constants for the trim, input-select and coefficient register bank.
// Assumes byte-wide register access over the link and 32-bit AHB-Lite on the host.
package tisc_pkg;

	// Device byte map: one contiguous bank plus the pin-function byte
	localparam logic [7:0]  BANK_BASE     = 8'h11;
	localparam logic [7:0]  BANK_LAST     = 8'h19;
	localparam int          BANK_BYTES    = 9;
	localparam logic [7:0]  TRIM_ADDR     = 8'h11;
	localparam logic [7:0]  SRC_ADDR      = 8'h15;
	localparam logic [7:0]  C2_ADDR       = 8'h16;
	localparam logic [7:0]  C3_ADDR       = 8'h18;
	localparam logic [7:0]  PIN_CFG_ADDR  = 8'h08;

	// Bank indices (byte address minus BANK_BASE)
	localparam int          TRIM_IDX      = 0;
	localparam int          SRC_IDX       = 4;
	localparam int          C2_IDX        = 5;
	localparam int          C3_IDX        = 7;

	// Source-select byte fields
	localparam int          SEL_HI_LSB    = 6;
	localparam int          SEL_LO_LSB    = 4;
	localparam int          BYP_IIR_BIT   = 2;
	localparam int          BYP_OSF_BIT   = 0;
	localparam logic [7:0]  SRC_RSVD_MASK = 8'h0A;

	// Pin-function byte: pin 0 in [3:0], pin 1 in [7:4]
	localparam logic [3:0]  PIN_FUNC_SEL  = 4'h9;

	// Reset values
	localparam logic [31:0] TRIM_RST      = 32'h7FFFFFFF;
	localparam logic [7:0]  SRC_RST       = 8'h00;
	localparam logic [15:0] COEF_RST      = 16'h0000;
	localparam logic [7:0]  PIN_CFG_RST   = 8'h00;
	localparam logic [71:0] BANK_RST      = {COEF_RST, COEF_RST, SRC_RST, TRIM_RST};

	// Sample arithmetic: samples and coefficients are Q1.15
	localparam int          FRAC_BITS     = 15;

	// Host AHB register offsets and fields
	localparam logic [7:0]  H_CMD_ADDR    = 8'h00;
	localparam logic [7:0]  H_STAT_ADDR   = 8'h04;
	localparam logic [7:0]  H_PIN_ADDR    = 8'h08;
	localparam int          CMD_WR_BIT    = 16;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		SRC_I2S   = 2'h0,
		SRC_SPDIF = 2'h1,
		SRC_RSVD  = 2'h2,
		SRC_DSD   = 2'h3
	} tisc_src_type;

	typedef enum logic [2:0] {
		HST_IDLE  = 3'h1,
		HST_ISSUE = 3'h2,
		HST_WAIT  = 3'h4
	} tisc_hstate_type;

endpackage

//--- verilog/tisc_link_if.sv
// Byte register link and selector pins between host controller and device.
// Both ends run on the same hclk; the interface itself holds no clock.
`timescale 1ns/1ps
interface tisc_link_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       rvalid;
	logic [1:0] sel_pin;

	modport dev (
		input  addr,
		input  wdata,
		input  wr,
		input  rd,
		input  sel_pin,
		output rdata,
		output rvalid
	);

	modport host (
		output addr,
		output wdata,
		output wr,
		output rd,
		output sel_pin,
		input  rdata,
		input  rvalid
	);
endinterface

//--- verilog/tisc_device.sv
// Device end: configuration bank for trim, source select, bypasses, coefficients.
// Assumes byte writes and reads arrive as single-cycle strobes on the link.
//
// Contract
// - Trim is 32 bits, LSB lowest, resets max.
// - Trim is the full-scale level for volume.
// - Host keeps trim signed, never above max; host passes trim bytes through unchecked.
// - Pin high selects source from bits 7:6.
// - Pin low selects source from bits 5:4.
// - Bit 2 set bypasses the IIR filter.
// - Bit 0 set bypasses 8x interpolation.
// - Bypassed interpolation needs 8x oversampled source.
// - Host writes zero to reserved bits 3,1.
// - Pin selects source only when function is nine.
// - Several selector pins: lowest numbered one wins.
// - Controller picks source by pin level.
// - Second-harmonic coefficient 16 bits, resets zero.
// - Third-harmonic coefficient 16 bits, resets zero.
// - Both coefficients are signed two's complement.
// - Compensation adds squared and cubed terms.
// - Uncompensated: PCM unchanged, DSD halved.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tisc_device
	import tisc_pkg::*;
(
	input  wire logic               hclk,
	input  wire logic               hresetn,
	tisc_link_if.dev                link,
	input  wire logic signed [15:0] sample_in,
	input  wire logic               sample_valid,
	input  wire logic               comp_enable,
	output logic signed [15:0]      audio_out,
	output logic                    audio_valid,
	output logic [31:0]             zero_level,
	output tisc_src_type            source_sel,
	output logic                    iir_bypass,
	output logic                    osf_bypass
);

	////////////////////////////////////////////////////////////////////////////////
	// Register storage

	logic [7:0]          bank_q [BANK_BYTES];
	logic [7:0]          pin_cfg_q;
	logic [7:0]          rdata_q;
	logic                rvalid_q;
	wire                 in_bank;
	wire                 cfg_hit;
	wire [7:0]           bank_idx;
	wire [7:0]           rdata_d;

	assign in_bank  = (link.addr >= BANK_BASE) && (link.addr <= BANK_LAST);
	assign cfg_hit  = (link.addr == PIN_CFG_ADDR);
	assign bank_idx = link.addr - BANK_BASE;

	// Multi-byte values change one byte per write, so a trim or coefficient
	// update passes through a mixed value for a few cycles; there is no shadow
	// One flop byte per address; each resets to its own slice of BANK_RST
	for (genvar i = 0; i < BANK_BYTES; i++) begin : g_bank
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				bank_q[i] <= BANK_RST[i*8 +: 8];
			end else if (link.wr && in_bank && (bank_idx == 8'(i))) begin
				bank_q[i] <= link.wdata;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_cfg_q <= PIN_CFG_RST;
		end else if (link.wr && cfg_hit) begin
			pin_cfg_q <= link.wdata;
		end
	end

	// Unmapped bytes read as zero; write-only side effects are none
	assign rdata_d = in_bank ? bank_q[bank_idx[3:0]] :
	                 cfg_hit ? pin_cfg_q : 8'h00;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= link.rd;
			// Data is taken only on a read so it stands until the next one
			if (link.rd) begin
				rdata_q <= rdata_d;
			end
		end
	end

	assign link.rdata  = rdata_q;
	assign link.rvalid = rvalid_q;

	////////////////////////////////////////////////////////////////////////////////
	// Assembled fields

	wire        [31:0] trim_w;
	wire        [7:0]  src_byte;
	wire signed [15:0] c2_w;
	wire signed [15:0] c3_w;

	assign trim_w   = {bank_q[TRIM_IDX+3], bank_q[TRIM_IDX+2],
	                   bank_q[TRIM_IDX+1], bank_q[TRIM_IDX]};
	assign src_byte = bank_q[SRC_IDX];
	assign c2_w     = {bank_q[C2_IDX+1], bank_q[C2_IDX]};
	assign c3_w     = {bank_q[C3_IDX+1], bank_q[C3_IDX]};

	////////////////////////////////////////////////////////////////////////////////
	// Source selection

	logic [1:0]   pin_q;
	wire          pin0_sel;
	wire          pin1_sel;
	wire          pin_level;
	wire [1:0]    choice;
	tisc_src_type src_q;

	// A pin steers the source only when its function nibble holds the selector code
	function automatic logic is_selector(input logic [3:0] func);
		is_selector = (func == PIN_FUNC_SEL);
	endfunction

	assign pin0_sel  = is_selector(pin_cfg_q[3:0]);
	assign pin1_sel  = is_selector(pin_cfg_q[7:4]);
	// Without any selector pin configured the low-level choice applies
	assign pin_level = pin0_sel ? pin_q[0] :
	                   pin1_sel ? pin_q[1] : 1'b0;
	assign choice    = pin_level ? src_byte[SEL_HI_LSB +: 2]
	                             : src_byte[SEL_LO_LSB +: 2];

	// Registered pin and choice keep the mux from glitching on pin edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_q      <= 2'h0;
			src_q      <= SRC_I2S;
			zero_level <= TRIM_RST;
			iir_bypass <= 1'b0;
			osf_bypass <= 1'b0;
		end else begin
			pin_q      <= link.sel_pin;
			src_q      <= tisc_src_type'(choice);
			zero_level <= trim_w;
			iir_bypass <= src_byte[BYP_IIR_BIT];
			osf_bypass <= src_byte[BYP_OSF_BIT];
		end
	end

	assign source_sel = src_q;

	////////////////////////////////////////////////////////////////////////////////
	// Harmonic compensation and full-scale scaling

	// Saturation keeps an over-driven compensation from wrapping around
	function automatic logic signed [15:0] sat16(input logic signed [19:0] v);
		if (v > 20'sh07FFF) begin
			sat16 = 16'sh7FFF;
		end else if (v < -20'sh08000) begin
			sat16 = -16'sh8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction

	wire signed [31:0] sq_full;
	wire signed [16:0] sq;
	wire signed [32:0] cu_full;
	wire signed [17:0] cu;
	wire signed [32:0] t2_full;
	wire signed [33:0] t3_full;
	wire signed [19:0] t2;
	wire signed [19:0] t3;
	wire signed [19:0] comp;
	wire signed [15:0] plain;
	wire signed [15:0] pre;
	wire signed [47:0] vol_full;

	assign sq_full = sample_in * sample_in;
	assign sq      = sq_full[31:FRAC_BITS];
	assign cu_full = sq * sample_in;
	assign cu      = cu_full[32:FRAC_BITS];
	assign t2_full = sq * c2_w;
	assign t3_full = cu * c3_w;
	// Part-selects come out unsigned; re-sign them or a negative term turns large
	assign t2      = 20'($signed(t2_full[32:FRAC_BITS]));
	assign t3      = 20'($signed(t3_full[33:FRAC_BITS]));
	assign comp    = 20'(sample_in) + t2 + t3;
	// DSD arrives at twice PCM level, so the plain path halves it
	assign plain   = (src_q == SRC_DSD) ? (sample_in >>> 1) : sample_in;
	assign pre     = comp_enable ? sat16(comp) : plain;
	// Trim is the unity point: full-scale trim passes the sample through
	assign vol_full = pre * $signed(zero_level);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			audio_out   <= 16'sh0000;
			audio_valid <= 1'b0;
		end else begin
			audio_valid <= sample_valid;
			if (sample_valid) begin
				// Bit 47 only repeats the sign of the 16x32 product
				audio_out <= vol_full[46:31];
			end
		end
	end

endmodule

//--- verilog/tisc_host.sv
// Host end: AHB-Lite slave whose commands become byte accesses on the link.
// Assumes one AHB master, single word transfers, and the device on the same hclk.
`timescale 1ns/1ps
module tisc_host
	import tisc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	tisc_link_if.host        link
);

	////////////////////////////////////////////////////////////////////////////////
	// AHB slave, zero wait states

	logic            wpend_q;
	logic [7:0]      waddr_q;
	logic [16:0]     cmd_q;
	logic [7:0]      rbyte_q;
	logic [1:0]      pin_q;
	tisc_hstate_type st_q;
	wire             ahb_go;
	wire             busy;
	wire             start;
	wire [31:0]      rmux;

	assign ahb_go = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign busy   = (st_q != HST_IDLE);
	// A command written while one is in flight is dropped
	assign start  = wpend_q && (waddr_q == H_CMD_ADDR) && !busy;
	assign rmux   = (haddr[7:0] == H_CMD_ADDR)  ? {15'h0000, cmd_q} :
	                (haddr[7:0] == H_STAT_ADDR) ? {16'h0000, rbyte_q, 7'h00, busy} :
	                (haddr[7:0] == H_PIN_ADDR)  ? {30'h00000000, pin_q} : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wpend_q   <= 1'b0;
			waddr_q   <= 8'h00;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wpend_q <= ahb_go && hwrite;
			if (ahb_go) begin
				waddr_q <= haddr[7:0];
			end
			if (ahb_go && !hwrite) begin
				hrdata <= rmux;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_q <= 17'h00000;
			pin_q <= 2'h0;
		end else begin
			if (start) begin
				cmd_q <= hwdata[16:0];
			end
			if (wpend_q && (waddr_q == H_PIN_ADDR)) begin
				pin_q <= hwdata[1:0];
			end
		end
	end

	assign link.sel_pin = pin_q;

	////////////////////////////////////////////////////////////////////////////////
	// Link sequencer

	logic [7:0] laddr_q;
	logic [7:0] lwdata_q;
	logic       lwr_q;
	logic       lrd_q;
	wire  [7:0] cmd_addr;
	wire  [7:0] cmd_wdata;

	assign cmd_addr  = hwdata[7:0];
	// Reserved source-select bits are forced low on every write
	assign cmd_wdata = (cmd_addr == SRC_ADDR) ? (hwdata[15:8] & ~SRC_RSVD_MASK)
	                                          : hwdata[15:8];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q     <= HST_IDLE;
			laddr_q  <= 8'h00;
			lwdata_q <= 8'h00;
			lwr_q    <= 1'b0;
			lrd_q    <= 1'b0;
			rbyte_q  <= 8'h00;
		end else begin
			unique case (st_q)
				HST_IDLE: begin
					if (start) begin
						laddr_q  <= cmd_addr;
						lwdata_q <= cmd_wdata;
						lwr_q    <= hwdata[CMD_WR_BIT];
						lrd_q    <= !hwdata[CMD_WR_BIT];
						st_q     <= HST_ISSUE;
					end
				end
				HST_ISSUE: begin
					lwr_q <= 1'b0;
					lrd_q <= 1'b0;
					st_q  <= lwr_q ? HST_IDLE : HST_WAIT;
				end
				HST_WAIT: begin
					if (link.rvalid) begin
						rbyte_q <= link.rdata;
						st_q    <= HST_IDLE;
					end
				end
			endcase
		end
	end

	assign link.addr  = laddr_q;
	assign link.wdata = lwdata_q;
	assign link.wr    = lwr_q;
	assign link.rd    = lrd_q;

endmodule

//--- tb/tisc_link_props.sv
// Concurrent checks on the byte link between the host and device ends.
// Assumes one hclk and that only the host end issues link strobes.
`timescale 1ns/1ps
module tisc_link_props
	import tisc_pkg::*;
(
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       rvalid,
	input wire logic [1:0] sel_pin
);
	////////////////////////////////////////////////////////////////////////////////
	// Shadow of every byte the device must hold, fed from observed writes
	logic [7:0] shadow_q [0:255];
	wire        mapped   = (addr == PIN_CFG_ADDR) || (addr >= BANK_BASE && addr <= BANK_LAST);
	wire  [7:0] exp_byte = mapped ? shadow_q[addr] : 8'h00;
	wire        in_trim  = addr >= TRIM_ADDR && addr < SRC_ADDR;
	wire        in_c2    = addr == C2_ADDR || addr == C2_ADDR + 8'h01;
	wire        in_c3    = addr == C3_ADDR || addr == C3_ADDR + 8'h01;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 256; i++) begin
				shadow_q[i] <= (i >= 17 && i <= 25) ? BANK_RST[8*(i-17) +: 8] : 8'h00;
			end
		end else if (wr && mapped) begin
			shadow_q[addr] <= wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_read_answer_next: assert property (rd |=> rvalid ##1 !rvalid)
		else $error("read strobe not answered in exactly one cycle");
	a_rvalid_cause: assert property (rvalid |-> $past(rd))
		else $error("read valid without a read strobe");
	a_rdata_holds: assert property (!rd |=> $stable(rdata))
		else $error("read data moved without a read");
	a_trim_kept: assert property (rd && in_trim |=> rdata == $past(exp_byte))
		else $error("trim byte read back wrong");
	a_src_kept: assert property (rd && addr == SRC_ADDR |=> rdata == $past(exp_byte))
		else $error("source select byte read back wrong");
	a_c2_kept: assert property (rd && in_c2 |=> rdata == $past(exp_byte))
		else $error("second harmonic byte read back wrong");
	a_c3_kept: assert property (rd && in_c3 |=> rdata == $past(exp_byte))
		else $error("third harmonic byte read back wrong");
	a_pin_cfg_kept: assert property (rd && addr == PIN_CFG_ADDR |=> rdata == $past(exp_byte))
		else $error("pin function byte read back wrong");
	a_rsvd_written_zero: assert property (wr && addr == SRC_ADDR |-> (wdata & SRC_RSVD_MASK) == 8'h00)
		else $error("reserved source bits written as one");

	c_src_write: cover property (wr && addr == SRC_ADDR);
	c_trim_read: cover property (rd && in_trim);
	c_pin_change: cover property ($changed(sel_pin));
endmodule

//--- tb/tisc_tb.sv
// Self-checking bench: AHB-Lite master drives the host end, which talks to the device end.
// Assumes zero-wait host answers are still waited for, and one shared 100 MHz hclk.
`timescale 1ns/1ps
module tisc_tb import tisc_pkg::*;;
	logic         hclk = 1'b0;
	logic         hresetn = 1'b0;
	logic         hsel = 1'b0;
	logic         hwrite = 1'b0;
	logic [1:0]   htrans = 2'h0;
	logic [2:0]   hsize = 3'h2;
	logic [31:0]  haddr = 32'h0;
	logic [31:0]  hwdata = 32'h0;
	logic [31:0]  hrdata;
	logic         hreadyout;
	logic         hresp;
	logic [15:0]  sample_in = 16'h0;
	logic         sample_valid = 1'b0;
	logic         comp_enable = 1'b0;
	logic [15:0]  audio_out;
	logic         audio_valid;
	logic [31:0]  zero_level;
	tisc_src_type source_sel;
	logic         iir_bypass;
	logic         osf_bypass;
	int           err_count = 0;
	int           tests_run = 0;

	tisc_link_if u_tisc_link_if ();
	tisc_host u_tisc_host (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .link(u_tisc_link_if));
	tisc_device u_tisc_device (.hclk, .hresetn, .link(u_tisc_link_if), .sample_in,
		.sample_valid, .comp_enable, .audio_out, .audio_valid, .zero_level, .source_sel,
		.iir_bypass, .osf_bypass);
	tisc_link_props u_tisc_link_props (.hclk, .hresetn, .addr(u_tisc_link_if.addr),
		.wdata(u_tisc_link_if.wdata), .wr(u_tisc_link_if.wr), .rd(u_tisc_link_if.rd),
		.rdata(u_tisc_link_if.rdata), .rvalid(u_tisc_link_if.rvalid),
		.sel_pin(u_tisc_link_if.sel_pin));

	always #5 hclk = ~hclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rv);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask

	// Busy is polled rather than counted so a slower sequencer still passes
	task automatic lop(input logic [7:0] a, input logic [7:0] d, input logic w,
		output logic [7:0] r);
		logic [31:0] st;
		ahb(H_CMD_ADDR, 1'b1, {15'h0000, w, d, a}, st);
		@(posedge hclk);
		do ahb(H_STAT_ADDR, 1'b0, 32'h0, st); while (st[0] !== 1'b0);
		r = st[15:8];
	endtask

	task automatic wb(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		lop(a, d, 1'b1, r);
	endtask

	task automatic rb(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		lop(a, 8'h00, 1'b0, r);
		chk({24'h0, r}, {24'h0, e});
	endtask

	task automatic src(input logic [1:0] p, input logic [1:0] e);
		logic [31:0] st;
		ahb(H_PIN_ADDR, 1'b1, {30'h0, p}, st);
		repeat (4) @(posedge hclk);
		#1;
		chk({30'h0, source_sel}, {30'h0, e});
	endtask

	task automatic audio(input logic [15:0] s, input logic [15:0] e);
		sample_in <= s;
		sample_valid <= 1'b1;
		@(posedge hclk);
		sample_valid <= 1'b0;
		#1;
		chk({15'h0, audio_valid, audio_out}, {16'h0001, e});
	endtask

	task automatic byp(input logic [7:0] v);
		wb(SRC_ADDR, v);
		chk({30'h0, iir_bypass, osf_bypass}, {30'h0, v[2], v[0]});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [31:0] st;
		for (int i = 0; i < 4; i++) rb(TRIM_ADDR + 8'(i), TRIM_RST[8*i +: 8]);
		rb(SRC_ADDR, 8'h00);
		rb(C2_ADDR + 8'h01, 8'h00);
		rb(C3_ADDR, 8'h00);
		rb(PIN_CFG_ADDR, 8'h00);
		rb(8'h30, 8'h00);
		chk({31'h0, hresp}, 32'h0);
		ahb(8'h0C, 1'b0, 32'h0, st);
		chk(st, 32'h0);
		chk(zero_level, 32'h7FFFFFFF);
		$display("test reset done");
	endtask

	task automatic t_trim;
		for (int i = 0; i < 4; i++) wb(TRIM_ADDR + 8'(i), i == 3 ? 8'h40 : 8'h00);
		chk(zero_level, 32'h40000000);
		rb(TRIM_ADDR + 8'h03, 8'h40);
		audio(16'h2000, 16'h1000);
		audio(16'hE000, 16'hF000);
		$display("test trim done");
	endtask

	task automatic t_select;
		wb(SRC_ADDR, 8'h70);
		src(2'b01, 2'd3);
		wb(PIN_CFG_ADDR, 8'h09);
		for (int c = 0; c < 4; c++) begin
			wb(SRC_ADDR, {2'(c), ~2'(c), 4'h0});
			src(2'b01, 2'(c));
			src(2'b00, ~2'(c));
		end
		wb(PIN_CFG_ADDR, 8'h99);
		rb(PIN_CFG_ADDR, 8'h99);
		wb(SRC_ADDR, 8'h70);
		src(2'b10, 2'd3);
		src(2'b01, 2'd1);
		wb(PIN_CFG_ADDR, 8'h90);
		src(2'b10, 2'd1);
		src(2'b00, 2'd3);
		audio(16'h2000, 16'h0800);
		$display("test select done");
	endtask

	task automatic t_bypass;
		byp(8'h04);
		byp(8'h01);
		byp(8'h00);
		wb(SRC_ADDR, 8'hFF);
		rb(SRC_ADDR, 8'hF5);
		$display("test bypass done");
	endtask

	task automatic t_comp;
		wb(SRC_ADDR, 8'h00);
		wb(C2_ADDR, 8'h00);
		wb(C2_ADDR + 8'h01, 8'h40);
		wb(C3_ADDR, 8'h00);
		wb(C3_ADDR + 8'h01, 8'hC0);
		rb(C2_ADDR + 8'h01, 8'h40);
		rb(C3_ADDR + 8'h01, 8'hC0);
		audio(16'h4000, 16'h2000);
		comp_enable <= 1'b1;
		audio(16'h4000, 16'h2400);
		$display("test comp done");
	endtask

	task automatic final_report;
		$display("checks=%0d mismatches=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_trim();
		t_select();
		t_bypass();
		t_comp();
		final_report();
	end

	// Whole run is a few hundred cycles; this leaves a wide margin
	initial begin
		#300000;
		err_count++;
		final_report();
	end
endmodule
